/* File: csa_pkg.sv */
// Shared constants, types and register map of the cascadable 16-bit ALU slice
// ==========================================================================
// ==========================================================================

package csa_pkg;

  // ========================================================================
  // Datapath sizes
  localparam int unsigned DATA_W = 16;
  localparam int unsigned FSEL_W = 5;

  // ========================================================================
  // Register map (byte addresses, word aligned)
  localparam logic [7:0] REG_CTRL_OFS   = 8'h00;
  localparam logic [7:0] REG_STATUS_OFS = 8'h04;
  localparam logic [7:0] REG_RESULT_OFS = 8'h08;
  localparam logic [7:0] REG_OPND_OFS   = 8'h0c;
  localparam int unsigned ADDR_W        = 8;

  // Control register fields
  localparam int unsigned CTRL_IN_BYP_BIT  = 0;
  localparam int unsigned CTRL_OUT_BYP_BIT = 1;
  localparam logic [1:0]  CTRL_RESET_VAL   = 2'h0;

  // Status register fields
  localparam int unsigned STAT_CARRY_BIT = 0;
  localparam int unsigned STAT_OVF_BIT   = 1;
  localparam int unsigned STAT_NEG_BIT   = 2;
  localparam int unsigned STAT_ZERO_BIT  = 3;

  // Reset value of the data registers and the all-ones operand constant
  localparam logic [15:0] DATA_RESET_VAL = 16'h0000;
  localparam logic [15:0] ALL_ONES       = 16'hffff;

  // AHB transfer type bit that marks an active transfer
  localparam int unsigned HTRANS_ACTIVE_BIT = 1;

  // ========================================================================
  // Function select codes
  typedef enum logic [4:0] {
    FN_A_PLUS_B     = 5'b00000,
    FN_A_OR_B       = 5'b00001,
    FN_A_PLUS_NB    = 5'b00010,
    FN_NA_PLUS_B    = 5'b00011,
    FN_A            = 5'b00100,
    FN_NA_OR_F      = 5'b00101,
    FN_A_MINUS_1    = 5'b00110,
    FN_NA           = 5'b00111,
    FN_A_PLUS_F     = 5'b01000,
    FN_A_OR_F       = 5'b01001,
    FN_A_PLUS_NF    = 5'b01010,
    FN_NA_PLUS_F    = 5'b01011,
    FN_F_PLUS_B     = 5'b01100,
    FN_NA_OR_B      = 5'b01101,
    FN_F_PLUS_NB    = 5'b01110,
    FN_NF_PLUS_B    = 5'b01111,
    FN_A_XOR_B      = 5'b10000,
    FN_A_AND_B      = 5'b10001,
    FN_NA_AND_B     = 5'b10010,
    FN_A_XNOR_B     = 5'b10011,
    FN_A_XOR_F      = 5'b10100,
    FN_A_AND_F      = 5'b10101,
    FN_NA_AND_F     = 5'b10110,
    FN_ONES         = 5'b10111,
    FN_B            = 5'b11000,
    FN_A_AND_NB     = 5'b11001,
    FN_NB           = 5'b11010,
    FN_B_MINUS_1    = 5'b11011,
    FN_F            = 5'b11100,
    FN_A_OR_NB      = 5'b11101,
    FN_F_MINUS_1    = 5'b11110,
    FN_NF           = 5'b11111
  } csa_func_t;

  // Status flags travelling together
  typedef struct packed {
    logic zero;
    logic negative;
    logic overflow;
    logic carry;
  } csa_flags_t;

endpackage : csa_pkg

/* File: csa_cla_adder.sv */
// Lookahead adder of one slice with carry-out and overflow
`timescale 1ns/1ns

module csa_cla_adder #(
  parameter int unsigned WIDTH = csa_pkg::DATA_W
) (
  // Operands and carry-in
  input  wire logic [WIDTH-1:0] x_in,
  input  wire logic [WIDTH-1:0] y_in,
  input  wire logic             cin,
  // Sum and carries
  output logic      [WIDTH-1:0] sum,
  output logic                  cout,
  output logic                  ovf
);

  // ========================================================================
  // Bit generate/propagate and group accumulation
  logic [WIDTH-1:0] gen_bit;
  logic [WIDTH-1:0] prop_bit;
  logic [WIDTH-1:0] grp_gen;
  logic [WIDTH-1:0] grp_prop;
  logic [WIDTH:0]   carry;

  assign carry[0] = cin;

  // One lookahead stage per bit
  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      assign gen_bit[i]  = x_in[i] & y_in[i];
      assign prop_bit[i] = x_in[i] | y_in[i];
      if (i == 0) begin : g_first
        assign grp_gen[i]  = gen_bit[i];
        assign grp_prop[i] = prop_bit[i];
      end else begin : g_rest
        assign grp_gen[i]  = gen_bit[i] | (prop_bit[i] & grp_gen[i-1]);
        assign grp_prop[i] = prop_bit[i] & grp_prop[i-1];
      end
      // Carry into the next bit from the group terms
      assign carry[i+1] = grp_gen[i] | (grp_prop[i] & cin);
      assign sum[i]     = x_in[i] ^ y_in[i] ^ carry[i];
    end
  endgenerate

  // Carry-out and signed overflow
  assign cout = carry[WIDTH];
  assign ovf  = carry[WIDTH-1] ^ carry[WIDTH];

endmodule : csa_cla_adder

/* File: csa_alu_top.sv */
// Cascadable ALU slice: operand, result and output registers plus AHB-Lite control
`timescale 1ns/1ns

module csa_alu_top #(
  parameter int unsigned WIDTH = csa_pkg::DATA_W
) (
  // Clock, reset and clock enable
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             clk_en,
  // Operand and function inputs
  input  wire logic [WIDTH-1:0] operand_a,
  input  wire logic [WIDTH-1:0] operand_b,
  input  wire logic [4:0]       function_select,
  input  wire logic             carry_in,
  // Register load enables, active low
  input  wire logic             operand_a_load_n,
  input  wire logic             operand_b_load_n,
  input  wire logic             result_load_n,
  // Result pin output enable, active low
  input  wire logic             output_enable_n,
  // Result pins and flags
  output logic      [WIDTH-1:0] result_out,
  output logic                  result_oe_n,
  output logic                  carry_out,
  output logic                  overflow_flag,
  output logic                  negative_flag,
  output logic                  zero_flag,
  // AHB-Lite slave
  input  wire logic             hsel,
  input  wire logic [31:0]      haddr,
  input  wire logic [1:0]       htrans,
  input  wire logic             hwrite,
  input  wire logic [2:0]       hsize,
  input  wire logic [31:0]      hwdata,
  input  wire logic             hready,
  output logic      [31:0]      hrdata,
  output logic                  hreadyout,
  output logic                  hresp
);

  // ========================================================================
  // Operand registers
  // Stages: A and B registers, result register, output flop
  logic [WIDTH-1:0] a_reg_ff;
  logic [WIDTH-1:0] b_reg_ff;
  logic [WIDTH-1:0] nxt_a_reg;
  logic [WIDTH-1:0] nxt_b_reg;

  // Next operand values under their own load enables
  always_comb begin
    nxt_a_reg = a_reg_ff;
    nxt_b_reg = b_reg_ff;
    if (clk_en && !operand_a_load_n) begin
      nxt_a_reg = operand_a;
    end
    if (clk_en && !operand_b_load_n) begin
      nxt_b_reg = operand_b;
    end
  end

  // Both operands share the rising edge; loading continues under bypass
  // Loading goes on under input bypass, so a fresh
  // copy is ready when the bypass is released
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      a_reg_ff <= csa_pkg::DATA_RESET_VAL;
      b_reg_ff <= csa_pkg::DATA_RESET_VAL;
    end else begin
      a_reg_ff <= nxt_a_reg;
      b_reg_ff <= nxt_b_reg;
    end
  end

  // ========================================================================
  // Control register (bypass controls, written over the bus)
  logic [1:0] ctrl_ff;
  logic [1:0] nxt_ctrl;
  logic       input_reg_bypass;
  logic       result_reg_bypass;

  assign input_reg_bypass  = ctrl_ff[csa_pkg::CTRL_IN_BYP_BIT];
  assign result_reg_bypass = ctrl_ff[csa_pkg::CTRL_OUT_BYP_BIT];
  // Both bypasses come up off, so the slice starts
  // with every register stage in the path

  // ========================================================================
  // Operand selection and function decode
  logic [WIDTH-1:0] opa;
  logic [WIDTH-1:0] opb;
  logic [WIDTH-1:0] opf;
  logic [WIDTH-1:0] add_x;
  logic [WIDTH-1:0] add_y;
  logic [WIDTH-1:0] logic_res;
  logic             is_arith;
  logic [WIDTH-1:0] result_reg_ff;

  // Bypass picks the live pins instead of the registers
  // F is the result register, never the output flop
  assign opa = input_reg_bypass ? operand_a : a_reg_ff;
  assign opb = input_reg_bypass ? operand_b : b_reg_ff;
  assign opf = result_reg_ff;

  // Adder operands or logic result per function code
  // Arithmetic codes reduce to x + y + carry_in, with x or y
  // zero or all ones on one-operand codes; logic codes skip the adder.
  // All 32 codes decode, so the default is unreachable
  always_comb begin
    add_x     = '0;
    add_y     = '0;
    logic_res = '0;
    is_arith  = 1'b1;
    case (csa_pkg::csa_func_t'(function_select))
      csa_pkg::FN_A_PLUS_B:  begin add_x = opa;  add_y = opb;  end
      csa_pkg::FN_A_PLUS_NB: begin add_x = opa;  add_y = ~opb; end
      csa_pkg::FN_NA_PLUS_B: begin add_x = ~opa; add_y = opb;  end
      csa_pkg::FN_A:         begin add_x = opa;  end
      csa_pkg::FN_A_MINUS_1: begin
        add_x = opa;
        add_y = csa_pkg::ALL_ONES[WIDTH-1:0];
      end
      csa_pkg::FN_NA:        begin add_x = ~opa; end
      csa_pkg::FN_A_PLUS_F:  begin add_x = opa;  add_y = opf;  end
      csa_pkg::FN_A_PLUS_NF: begin add_x = opa;  add_y = ~opf; end
      csa_pkg::FN_NA_PLUS_F: begin add_x = ~opa; add_y = opf;  end
      csa_pkg::FN_F_PLUS_B:  begin add_x = opf;  add_y = opb;  end
      csa_pkg::FN_F_PLUS_NB: begin add_x = opf;  add_y = ~opb; end
      csa_pkg::FN_NF_PLUS_B: begin add_x = ~opf; add_y = opb;  end
      csa_pkg::FN_F:         begin add_x = opf;  end
      csa_pkg::FN_F_MINUS_1: begin
        add_x = opf;
        add_y = csa_pkg::ALL_ONES[WIDTH-1:0];
      end
      csa_pkg::FN_NF:        begin add_x = ~opf; end
      csa_pkg::FN_ONES:      begin
        add_x = csa_pkg::ALL_ONES[WIDTH-1:0];
      end
      csa_pkg::FN_B:         begin add_y = opb;  end
      csa_pkg::FN_NB:        begin add_y = ~opb; end
      csa_pkg::FN_B_MINUS_1: begin
        add_x = csa_pkg::ALL_ONES[WIDTH-1:0];
        add_y = opb;
      end
      csa_pkg::FN_A_OR_B:    begin is_arith = 1'b0; logic_res = opa | opb;    end
      csa_pkg::FN_NA_OR_F:   begin is_arith = 1'b0; logic_res = ~opa | opf;   end
      csa_pkg::FN_A_OR_F:    begin is_arith = 1'b0; logic_res = opa | opf;    end
      csa_pkg::FN_NA_OR_B:   begin is_arith = 1'b0; logic_res = ~opa | opb;   end
      csa_pkg::FN_A_XOR_B:   begin is_arith = 1'b0; logic_res = opa ^ opb;    end
      csa_pkg::FN_A_AND_B:   begin is_arith = 1'b0; logic_res = opa & opb;    end
      csa_pkg::FN_NA_AND_B:  begin is_arith = 1'b0; logic_res = ~opa & opb;   end
      csa_pkg::FN_A_XNOR_B:  begin is_arith = 1'b0; logic_res = ~(opa ^ opb); end
      csa_pkg::FN_A_XOR_F:   begin is_arith = 1'b0; logic_res = opa ^ opf;    end
      csa_pkg::FN_A_AND_F:   begin is_arith = 1'b0; logic_res = opa & opf;    end
      csa_pkg::FN_NA_AND_F:  begin is_arith = 1'b0; logic_res = ~opa & opf;   end
      csa_pkg::FN_A_AND_NB:  begin is_arith = 1'b0; logic_res = opa & ~opb;   end
      csa_pkg::FN_A_OR_NB:   begin is_arith = 1'b0; logic_res = opa | ~opb;   end
      default:               begin is_arith = 1'b0; logic_res = '0;           end
    endcase
  end

  // ========================================================================
  // Adder and result flags
  logic [WIDTH-1:0]    sum;
  logic                add_cout;
  logic                add_ovf;
  logic [WIDTH-1:0]    alu_res;
  csa_pkg::csa_flags_t alu_flags;

  csa_cla_adder #(
    .WIDTH (WIDTH)
  ) u_adder (
    .x_in  (add_x),
    .y_in  (add_y),
    .cin   (carry_in),
    .sum   (sum),
    .cout  (add_cout),
    .ovf   (add_ovf)
  );

  // Flags follow the live ALU result; carry and overflow cleared for logic
  // A stray carry on a logic code could mislead the
  // next slice of a cascade, so it is held at zero
  always_comb begin
    alu_res            = is_arith ? sum : logic_res;
    alu_flags.carry    = is_arith & add_cout;
    alu_flags.overflow = is_arith & add_ovf;
    alu_flags.negative = alu_res[WIDTH-1];
    alu_flags.zero     = (alu_res == '0);
  end

  // ========================================================================
  // Result register
  logic [WIDTH-1:0] nxt_result_reg;

  // Load on low enable, otherwise hold the previous result
  always_comb begin
    nxt_result_reg = result_reg_ff;
    if (clk_en && !result_load_n) begin
      nxt_result_reg = alu_res;
    end
  end

  // Keeps working under output bypass
  // Also the fed-back F operand: holding the load
  // enable high keeps F fixed across a chain of codes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_reg_ff <= csa_pkg::DATA_RESET_VAL;
    end else begin
      result_reg_ff <= nxt_result_reg;
    end
  end

  // ========================================================================
  // Output stage: result data and flags leave from flip-flops
  logic [WIDTH-1:0]    out_data_ff;
  logic [WIDTH-1:0]    nxt_out_data;
  csa_pkg::csa_flags_t flags_ff;
  csa_pkg::csa_flags_t nxt_flags;

  // Bypass shows the ALU result, otherwise the result register
  // The next register value is shown, so a result is
  // on the pins right after the edge that loads it
  always_comb begin
    nxt_out_data = out_data_ff;
    nxt_flags    = flags_ff;
    if (clk_en) begin
      nxt_out_data = result_reg_bypass ? alu_res : nxt_result_reg;
      nxt_flags    = alu_flags;
    end
  end

  // Output registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_data_ff <= csa_pkg::DATA_RESET_VAL;
      flags_ff    <= '0;
    end else begin
      out_data_ff <= nxt_out_data;
      flags_ff    <= nxt_flags;
    end
  end

  assign result_out    = out_data_ff;
  assign carry_out     = flags_ff.carry;
  assign overflow_flag = flags_ff.overflow;
  assign negative_flag = flags_ff.negative;
  assign zero_flag     = flags_ff.zero;
  // Enable passes straight through so bus hand-over needs no clock
  // The only output without a flop: a registered copy
  // would fight another driver for a cycle on hand-over
  assign result_oe_n   = output_enable_n;

  // ========================================================================
  // AHB-Lite slave: zero-wait, always OKAY
  // Only the low address byte decodes, so the map repeats;
  // hsize is not checked, every access is a full word.
  // Accesses are lost while clk_en is low
  logic                              wr_pend_ff;
  logic                              nxt_wr_pend;
  logic [csa_pkg::ADDR_W-1:0]        wr_addr_ff;
  logic [csa_pkg::ADDR_W-1:0]        nxt_wr_addr;
  logic [31:0]                       rdata_ff;
  logic [31:0]                       nxt_rdata;
  logic                              addr_take;
  logic [csa_pkg::ADDR_W-1:0]        addr_lo;

  assign addr_take = hsel & htrans[csa_pkg::HTRANS_ACTIVE_BIT] & hready;
  assign addr_lo   = haddr[csa_pkg::ADDR_W-1:0];

  // Address phase capture, read data mux and control write
  always_comb begin
    nxt_wr_pend = wr_pend_ff;
    nxt_wr_addr = wr_addr_ff;
    nxt_rdata   = rdata_ff;
    nxt_ctrl    = ctrl_ff;
    if (clk_en) begin
      // Data phase of a pending write to the control offset lands in the control register
      if (wr_pend_ff && (wr_addr_ff == csa_pkg::REG_CTRL_OFS)) begin
        nxt_ctrl = hwdata[1:0];
      end
      nxt_wr_pend = addr_take & hwrite;
      nxt_wr_addr = addr_lo;
      nxt_rdata   = '0;
      if (addr_take && !hwrite) begin
        // Captured at the address edge, it stands for
        // the whole data phase that follows
        case (addr_lo)
          csa_pkg::REG_CTRL_OFS:   nxt_rdata = {30'h0, ctrl_ff};
          csa_pkg::REG_STATUS_OFS: nxt_rdata = {28'h0, flags_ff};
          csa_pkg::REG_RESULT_OFS: nxt_rdata = {16'h0, result_reg_ff};
          csa_pkg::REG_OPND_OFS:   nxt_rdata = {b_reg_ff, a_reg_ff};
          default:                 nxt_rdata = '0;
        endcase
      end
    end
  end

  // Bus-side registers
  // A pending write keeps its address until hwdata comes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= '0;
      rdata_ff   <= '0;
      ctrl_ff    <= csa_pkg::CTRL_RESET_VAL;
    end else begin
      wr_pend_ff <= nxt_wr_pend;
      wr_addr_ff <= nxt_wr_addr;
      rdata_ff   <= nxt_rdata;
      ctrl_ff    <= nxt_ctrl;
    end
  end

  // Ready and response flops; slave never stretches a transfer
  logic ready_ff;
  logic resp_ff;
  logic nxt_ready;
  logic nxt_resp;

  // Constant answers: zero wait states, always OKAY
  always_comb begin
    nxt_ready = 1'b1;
    nxt_resp  = 1'b0;
  end

  // Registered so both bus outputs leave flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ready_ff <= 1'b1;
      resp_ff  <= 1'b0;
    end else begin
      ready_ff <= nxt_ready;
      resp_ff  <= nxt_resp;
    end
  end

  assign hrdata    = rdata_ff;
  assign hreadyout = ready_ff;
  assign hresp     = resp_ff;

endmodule : csa_alu_top

/* File: csa_alu_sva.sv */
// Assertion checker on the ports of the ALU slice
`timescale 1ns/1ns

module csa_alu_sva #(
  parameter int unsigned WIDTH = csa_pkg::DATA_W
) (
  // Clock, reset and enable
  input wire logic             hclk,
  input wire logic             hresetn,
  input wire logic             clk_en,
  // Slice controls and results
  input wire logic [4:0]       function_select,
  input wire logic             output_enable_n,
  input wire logic [WIDTH-1:0] result_out,
  input wire logic             result_oe_n,
  input wire logic             carry_out,
  input wire logic             overflow_flag,
  input wire logic             negative_flag,
  input wire logic             zero_flag,
  // Bus side
  input wire logic             hsel,
  input wire logic [31:0]      haddr,
  input wire logic [1:0]       htrans,
  input wire logic             hwrite,
  input wire logic             hready,
  input wire logic [31:0]      hrdata,
  input wire logic             hreadyout,
  input wire logic             hresp
);
  // ==========================================================================
  // Helper decode
  logic is_logic;
  logic rd_req;
  assign is_logic = function_select inside {5'h01, 5'h05, 5'h09, 5'h0d, 5'h10, 5'h11, 5'h12,
                                            5'h13, 5'h14, 5'h15, 5'h16, 5'h19, 5'h1d};
  assign rd_req = hsel && htrans[1] && !hwrite && hready && clk_en;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // ==========================================================================
  // Properties
  property p_oe_follow;
    result_oe_n == output_enable_n;
  endproperty
  a_oe_follow: assert property (p_oe_follow) else $error("pin enable mismatch");
  property p_logic_carry;
    is_logic && clk_en |=> carry_out == 1'b0;
  endproperty
  a_logic_carry: assert property (p_logic_carry) else $error("carry on logic op");
  property p_logic_ovf;
    is_logic && clk_en |-> ##1 !overflow_flag;
  endproperty
  a_logic_ovf: assert property (p_logic_ovf) else $error("overflow on logic op");
  property p_zero_neg;
    !(zero_flag && negative_flag);
  endproperty
  a_zero_neg: assert property (p_zero_neg) else $error("zero and negative");
  property p_freeze;
    !clk_en |=> $stable(result_out) && $stable(zero_flag) && $stable(carry_out);
  endproperty
  a_freeze: assert property (p_freeze) else $error("outputs moved while frozen");
  property p_ready;
    hreadyout && !hresp;
  endproperty
  a_ready: assert property (p_ready) else $error("bus not ready or error");
  property p_unmapped;
    rd_req && haddr[7:4] != 4'h0 |=> hrdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_rd_idle;
    !rd_req && clk_en |-> ##1 hrdata == 32'h0;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data without read");
  cover property (is_logic);
endmodule : csa_alu_sva

/* File: csa_ctl_model.sv */
// Controller model that drives the operand side of the slice
`timescale 1ns/1ns

module csa_ctl_model (
  // Clock
  input  wire logic        hclk,
  // Operand side of the slice
  output logic      [15:0] operand_a,
  output logic      [15:0] operand_b,
  output logic      [4:0]  function_select,
  output logic             carry_in,
  output logic      [2:0]  load_n
);
  // Idle levels: all loads off
  initial begin
    operand_a = 16'h0000;
    operand_b = 16'h0000;
    function_select = 5'h00;
    carry_in = 1'b0;
    load_n = 3'h7;
  end
  // One step launched just after a rising edge
  task automatic step(input logic [15:0] a, input logic [15:0] b, input logic [4:0] fs,
                      input logic ci, input logic [2:0] ld_n);
    @(posedge hclk);
    operand_a <= a;
    operand_b <= b;
    function_select <= fs; // Shared by every slice
    carry_in <= ci; // Fed from the lower slice carry
    load_n <= ld_n; // Shared enables
  endtask : step
  // Zero of a two-slice cascade
  function automatic logic cascade_zero(input logic z_lo, input logic z_hi);
    return z_lo & z_hi;
  endfunction : cascade_zero
endmodule : csa_ctl_model

/* File: tb.sv */
// Self-checking testbench of the ALU slice
`timescale 1ns/1ns

module tb;
  // ==========================================================================
  // Signals
  localparam logic [15:0] F_VAL = 16'h00ff;
  logic        hclk, hresetn, clk_en, output_enable_n, hsel, hwrite;
  logic [31:0] haddr, hwdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [15:0] r;
  wire logic [15:0] op_a, op_b, result_out;
  wire logic [4:0]  fsel;
  wire logic [2:0]  ld_n;
  wire logic        cin, oe_n, c_out, ovf, neg, zero, hreadyout, hresp;
  wire logic [31:0] hrdata;
  int bad_count, check_count;

  csa_ctl_model u_csa_ctl_model (.hclk(hclk), .operand_a(op_a), .operand_b(op_b),
    .function_select(fsel), .carry_in(cin), .load_n(ld_n));
  csa_alu_top u_csa_alu_top (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en),
    .operand_a(op_a), .operand_b(op_b), .function_select(fsel), .carry_in(cin),
    .operand_a_load_n(ld_n[2]), .operand_b_load_n(ld_n[1]), .result_load_n(ld_n[0]),
    .output_enable_n(output_enable_n), .result_out(result_out), .result_oe_n(oe_n),
    .carry_out(c_out), .overflow_flag(ovf), .negative_flag(neg), .zero_flag(zero),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp));

  // ==========================================================================
  // Clock and watchdog
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    bad_count++;
    summarize();
  end

  // ==========================================================================
  // Shared tasks
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= addr;
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb
  // Reference result: {overflow, carry, result}
  function automatic logic [17:0] ref_alu(input logic [4:0] s, input logic [15:0] a, b, f,
                                          input logic c);
    logic [15:0] x, y, lo;
    logic [16:0] sm;
    logic        lg;
    {lg, x, y} = {1'b0, 32'h0};
    case (s)
      5'h00: {x, y} = {a, b};
      5'h02: {x, y} = {a, ~b};
      5'h03: {x, y} = {~a, b};
      5'h04: x = a;
      5'h06: {x, y} = {a, 16'hffff};
      5'h07: x = ~a;
      5'h08: {x, y} = {a, f};
      5'h0a: {x, y} = {a, ~f};
      5'h0b: {x, y} = {~a, f};
      5'h0c: {x, y} = {f, b};
      5'h0e: {x, y} = {f, ~b};
      5'h0f: {x, y} = {~f, b};
      5'h17: x = 16'hffff;
      5'h18: x = b;
      5'h1a: x = ~b;
      5'h1b: {x, y} = {b, 16'hffff};
      5'h1c: x = f;
      5'h1e: {x, y} = {f, 16'hffff};
      5'h1f: x = ~f;
      5'h01: {lg, x} = {1'b1, a | b};
      5'h05: {lg, x} = {1'b1, ~a | f};
      5'h09: {lg, x} = {1'b1, a | f};
      5'h0d: {lg, x} = {1'b1, ~a | b};
      5'h10: {lg, x} = {1'b1, a ^ b};
      5'h11: {lg, x} = {1'b1, a & b};
      5'h12: {lg, x} = {1'b1, ~a & b};
      5'h13: {lg, x} = {1'b1, ~(a ^ b)};
      5'h14: {lg, x} = {1'b1, a ^ f};
      5'h15: {lg, x} = {1'b1, a & f};
      5'h16: {lg, x} = {1'b1, ~a & f};
      5'h19: {lg, x} = {1'b1, a & ~b};
      default: {lg, x} = {1'b1, a | ~b};
    endcase
    sm = {1'b0, x} + {1'b0, y} + {16'h0, c};
    lo = {1'b0, x[14:0]} + {1'b0, y[14:0]} + {15'h0, c};
    return lg ? {2'b00, x} : {lo[15] ^ sm[16], sm[16], sm[15:0]};
  endfunction : ref_alu

  // ==========================================================================
  // Scenarios
  task automatic t_funcs(input logic [15:0] a, input logic [15:0] b, input logic pol);
    logic [17:0] e;
    for (int i = 0; i < 32; i++) begin
      u_csa_ctl_model.step(a, b, 5'(i), pol ^ i[0], 3'h7);
      @(posedge hclk);
      #1;
      e = ref_alu(5'(i), a, b, F_VAL, pol ^ i[0]);
      chk("result_out", 32'(e[15:0]), 32'(result_out));
      chk("carry_out", 32'(e[16]), 32'(c_out));
      chk("overflow_flag", 32'(e[17]), 32'(ovf));
      chk("negative_flag", 32'(e[15]), 32'(neg));
      chk("zero_flag", 32'(e[15:0] == 16'h0), 32'(zero));
    end
  endtask : t_funcs
  task automatic t_regs;
    ahb(1'b1, 32'h0, 32'h0);
    u_csa_ctl_model.step(16'h0003, 16'h0005, 5'h00, 1'b0, 3'h1);
    u_csa_ctl_model.step(16'hf0f0, 16'h1111, 5'h00, 1'b0, 3'h6);
    u_csa_ctl_model.step(16'h0f0f, 16'h2222, 5'h00, 1'b0, 3'h7);
    @(posedge hclk);
    #1;
    chk("held result", 32'h8, 32'(result_out));
    ahb(1'b0, 32'h0c, 32'h0);
    chk("operand regs", 32'h00050003, rd);
    ahb(1'b1, 32'h0, 32'h3);
    u_csa_ctl_model.step(16'h0100, 16'h0200, 5'h00, 1'b0, 3'h1);
    u_csa_ctl_model.step(16'h0010, 16'h0020, 5'h00, 1'b0, 3'h7);
    @(posedge hclk);
    #1;
    chk("bypassed sum", 32'h30, 32'(result_out));
    ahb(1'b1, 32'h0, 32'h2);
    repeat (2) @(posedge hclk);
    #1;
    chk("register sum", 32'h300, 32'(result_out));
  endtask : t_regs
  task automatic t_pins;
    @(posedge hclk);
    output_enable_n <= 1'b1;
    #1;
    chk("result_oe_n", 32'h1, 32'(oe_n));
    output_enable_n <= 1'b0;
    #1;
    chk("result_oe_n", 32'h0, 32'(oe_n));
    @(posedge hclk);
    clk_en <= 1'b0;
    #1;
    r = result_out;
    u_csa_ctl_model.step(16'h7777, 16'h1111, 5'h00, 1'b1, 3'h0);
    @(posedge hclk);
    #1;
    chk("frozen result", 32'(r), 32'(result_out));
    clk_en <= 1'b1;
  endtask : t_pins

  // ==========================================================================
  // Main sequence
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {clk_en, output_enable_n, hsize} = {1'b1, 1'b0, 3'h2};
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, 32'h0c, 32'h0);
    chk("operand regs at reset", 32'h0, rd);
    ahb(1'b1, 32'h0, 32'h3);
    ahb(1'b0, 32'h0, 32'h0);
    chk("control", 32'h3, rd);
    ahb(1'b0, 32'h40, 32'h0);
    chk("unmapped", 32'h0, rd);
    u_csa_ctl_model.step(16'h0000, F_VAL, 5'h18, 1'b0, 3'h6);
    ahb(1'b0, 32'h08, 32'h0);
    chk("result reg", 32'(F_VAL), rd);
    t_funcs(16'h8001, 16'h7fff, 1'b0);
    t_funcs(16'h1234, 16'h1234, 1'b1);
    t_regs();
    t_pins();
    summarize();
  end
  task automatic summarize;
    if (bad_count == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : summarize
endmodule : tb

bind csa_alu_top csa_alu_sva #(.WIDTH(WIDTH)) u_csa_alu_sva (.hclk(hclk), .hresetn(hresetn),
  .clk_en(clk_en), .function_select(function_select), .output_enable_n(output_enable_n),
  .result_out(result_out), .result_oe_n(result_oe_n), .carry_out(carry_out),
  .overflow_flag(overflow_flag), .negative_flag(negative_flag), .zero_flag(zero_flag),
  .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp));
